//--- hdl/gpc_pin_sync.sv
// Three-stage pin input synchroniser with agreement filter
module gpc_pin_sync #(
  parameter int WIDTH = 16
) (
  input  wire logic             clk,
  input  wire logic             rst,
  input  wire logic             ce,
  input  wire logic [WIDTH-1:0] async_in,
  output logic      [WIDTH-1:0] sync_out
);

  // ==========================================================
  // Stages
  logic [WIDTH-1:0] stage1;
  logic [WIDTH-1:0] stage2;
  logic [WIDTH-1:0] stage3;
  wire  [WIDTH-1:0] agree = ~(stage2 ^ stage3);
  wire  [WIDTH-1:0] next_sync_out =
    (stage2 & agree) | (sync_out & ~agree);

  // Stage1 feeds only stage2 so metastability cannot leak
  always_ff @(posedge clk) begin
    if (rst) begin
      stage1   <= '0;
      stage2   <= '0;
      stage3   <= '0;
      sync_out <= '0;
    end else if (ce) begin
      stage1   <= async_in;
      stage2   <= stage1;
      stage3   <= stage2;
      sync_out <= next_sync_out;
    end
  end

endmodule : gpc_pin_sync

//--- hdl/gpc_port.sv
// Eight-bit bidirectional GPIO port with APB register access
//
// Function
// - Eight pins, each with direction, latch, readback.
// - Direction 1 turns the pin driver off.
// - Direction 0 drives pin from output latch.
// - Port reads return pins; writes load latch.
// - Port writes merge sampled pins, then latch.
// - Direction still governs drivers of analog pins.
// - Open-drain bit per pin: sink only.
// - Open-drain clear: push-pull drive both ways.
// - Slew-limit bit per pin, else full rate.
// - Threshold select governs reads and change detection.
// - Threshold 1 Schmitt, 0 TTL levels.
// - Analog select forces digital reads to zero.
// - Analog select leaves digital output untouched.
// - Analog select bits reset to analog mode.
// - Two pins get a high-drive strength bit.
// - Latch drives pins unless pin select overrides.
// - Analog functions active only under analog select.
module gpc_port #(
  parameter int WIDTH = gpc_pkg::PORT_W
) (
  input  wire logic                      clk,
  input  wire logic                      rst,
  input  wire logic                      por,
  input  wire logic                      ce,
  // APB slave
  input  wire logic                      psel,
  input  wire logic                      penable,
  input  wire logic                      pwrite,
  input  wire logic [gpc_pkg::APB_AW-1:0] paddr,
  input  wire logic [gpc_pkg::APB_DW-1:0] pwdata,
  input  wire logic [3:0]                pstrb,
  output logic                           pready,
  output logic      [gpc_pkg::APB_DW-1:0] prdata,
  output logic                           pslverr,
  // Pad side
  input  wire logic [WIDTH-1:0]          pin_in_schmitt,
  input  wire logic [WIDTH-1:0]          pin_in_ttl,
  output logic      [WIDTH-1:0]          port_pins_out,
  output logic      [WIDTH-1:0]          port_pins_oe,
  output logic      [WIDTH-1:0]          pin_slew_limit,
  output logic      [WIDTH-1:0]          pin_high_drive,
  output logic      [WIDTH-1:0]          pin_analog_enable,
  // Peripheral side
  input  wire logic [WIDTH-1:0]          periph_select,
  input  wire logic [WIDTH-1:0]          periph_out,
  output logic      [WIDTH-1:0]          pin_digital_in
);

  // ==========================================================
  // Helpers
  function automatic logic [WIDTH-1:0] gpc_merge(
    input logic [WIDTH-1:0] old_val,
    input logic [WIDTH-1:0] new_val,
    input logic [WIDTH-1:0] mask
  );
    gpc_merge = (old_val & ~mask) | (new_val & mask);
  endfunction : gpc_merge

  function automatic logic [gpc_pkg::APB_DW-1:0] gpc_widen(
    input logic [WIDTH-1:0] v
  );
    gpc_widen = {{(gpc_pkg::APB_DW - WIDTH){1'b0}}, v};
  endfunction : gpc_widen

  // ==========================================================
  // Registers
  logic [WIDTH-1:0] pin_direction;
  logic [WIDTH-1:0] output_latch;
  logic [WIDTH-1:0] open_drain_select;
  logic [WIDTH-1:0] slew_limit_select;
  logic [WIDTH-1:0] input_threshold_select;
  logic [WIDTH-1:0] analog_select;
  logic [WIDTH-1:0] high_drive_select;
  logic [WIDTH-1:0] port_write_mask;
  logic             bus_ack;

  // ==========================================================
  // Input path
  logic [2*WIDTH-1:0] pins_sync;

  gpc_pin_sync #(
    .WIDTH (2*WIDTH)
  ) u_sync (
    .clk      (clk),
    .rst      (rst),
    .ce       (ce),
    .async_in ({pin_in_schmitt, pin_in_ttl}),
    .sync_out (pins_sync)
  );

  wire [WIDTH-1:0] sync_schmitt = pins_sync[2*WIDTH-1:WIDTH];
  wire [WIDTH-1:0] sync_ttl     = pins_sync[WIDTH-1:0];
  // Muxing after the synchroniser keeps a threshold change
  // from disturbing the sampling stages
  wire [WIDTH-1:0] pin_level =
    (sync_schmitt & input_threshold_select) |
    (sync_ttl & ~input_threshold_select);
  wire [WIDTH-1:0] pin_read = pin_level & ~analog_select;

  // Same masked level feeds port reads and change detection
  assign pin_digital_in    = pin_read;
  assign pin_analog_enable = analog_select;

  // ==========================================================
  // Output path
  wire [WIDTH-1:0] drive_src =
    gpc_merge(output_latch, periph_out, periph_select);
  // Analog select deliberately absent from the drive terms
  wire [WIDTH-1:0] drive_on = ~pin_direction;
  // Open drain: enable only while pulling low, never drive high
  wire [WIDTH-1:0] next_oe =
    drive_on & (~open_drain_select | ~drive_src);
  wire [WIDTH-1:0] next_out =
    drive_src & ~open_drain_select;

  always_ff @(posedge clk) begin
    if (rst || por) begin
      port_pins_oe  <= '0;
      port_pins_out <= '0;
    end else if (ce) begin
      port_pins_oe  <= next_oe;
      port_pins_out <= next_out;
    end
  end

  assign pin_slew_limit = slew_limit_select;
  assign pin_high_drive = high_drive_select;

  // ==========================================================
  // APB decode
  wire             setup    = psel & ~penable & ~bus_ack;
  wire             complete = psel & penable & bus_ack & ce;
  wire             do_write = complete & pwrite & pstrb[0];
  wire [WIDTH-1:0] wdata    = pwdata[WIDTH-1:0];

  wire hit_port  = paddr == gpc_pkg::OFS_PORT_PIN_VALUE;
  wire hit_dir   = paddr == gpc_pkg::OFS_PIN_DIRECTION;
  wire hit_lat   = paddr == gpc_pkg::OFS_OUTPUT_LATCH;
  wire hit_od    = paddr == gpc_pkg::OFS_OPEN_DRAIN;
  wire hit_slew  = paddr == gpc_pkg::OFS_SLEW_LIMIT;
  wire hit_thr   = paddr == gpc_pkg::OFS_INPUT_THRESHOLD;
  wire hit_ana   = paddr == gpc_pkg::OFS_ANALOG_SELECT;
  wire hit_hdrv  = paddr == gpc_pkg::OFS_HIGH_DRIVE;
  wire hit_wmask = paddr == gpc_pkg::OFS_WRITE_MASK;
  wire hit_any   = hit_port | hit_dir | hit_lat | hit_od |
                   hit_slew | hit_thr | hit_ana | hit_hdrv |
                   hit_wmask;

  // Port write: sample pins, patch masked bits, store in latch
  wire [WIDTH-1:0] rmw_value =
    gpc_merge(pin_read, wdata, port_write_mask);

  wire [gpc_pkg::APB_DW-1:0] read_mux =
    hit_port  ? gpc_widen(pin_read) :
    hit_dir   ? gpc_widen(pin_direction) :
    hit_lat   ? gpc_widen(output_latch) :
    hit_od    ? gpc_widen(open_drain_select) :
    hit_slew  ? gpc_widen(slew_limit_select) :
    hit_thr   ? gpc_widen(input_threshold_select) :
    hit_ana   ? gpc_widen(analog_select) :
    hit_hdrv  ? gpc_widen(high_drive_select) :
    hit_wmask ? gpc_widen(port_write_mask) :
                gpc_pkg::READ_ZERO;

  assign pready = penable & bus_ack & ce;

  // Read data and error are captured in the setup cycle
  always_ff @(posedge clk) begin
    if (rst) begin
      bus_ack <= 1'b0;
      prdata  <= gpc_pkg::READ_ZERO;
      pslverr <= 1'b0;
    end else if (ce) begin
      if (setup) begin
        bus_ack <= 1'b1;
        prdata  <= pwrite ? gpc_pkg::READ_ZERO : read_mux;
        pslverr <= ~hit_any;
      end else if (complete) begin
        bus_ack <= 1'b0;
      end
    end
  end

  // ==========================================================
  // Register writes
  always_ff @(posedge clk) begin
    if (rst || por) begin
      pin_direction <= gpc_pkg::RST_PIN_DIRECTION;
    end else if (do_write && hit_dir) begin
      pin_direction <= wdata;
    end
  end

  // Only power-on clears the latch; other resets leave it alone
  always_ff @(posedge clk) begin
    if (por) begin
      output_latch <= gpc_pkg::RST_OUTPUT_LATCH;
    end else if (do_write && hit_port) begin
      output_latch <= rmw_value;
    end else if (do_write && hit_lat) begin
      output_latch <= wdata;
    end
  end

  always_ff @(posedge clk) begin
    if (rst || por) begin
      open_drain_select <= gpc_pkg::RST_OPEN_DRAIN;
    end else if (do_write && hit_od) begin
      open_drain_select <= wdata;
    end
  end

  always_ff @(posedge clk) begin
    if (rst || por) begin
      slew_limit_select <= gpc_pkg::RST_SLEW_LIMIT;
    end else if (do_write && hit_slew) begin
      slew_limit_select <= wdata;
    end
  end

  always_ff @(posedge clk) begin
    if (rst || por) begin
      input_threshold_select <= gpc_pkg::RST_INPUT_THRESHOLD;
    end else if (do_write && hit_thr) begin
      input_threshold_select <= wdata;
    end
  end

  // Unimplemented analog bits stay zero
  always_ff @(posedge clk) begin
    if (rst || por) begin
      analog_select <= gpc_pkg::RST_ANALOG_SELECT;
    end else if (do_write && hit_ana) begin
      analog_select <= wdata & gpc_pkg::MASK_ANALOG_SELECT;
    end
  end

  // Only the two high-drive pins hold a bit
  always_ff @(posedge clk) begin
    if (rst || por) begin
      high_drive_select <= gpc_pkg::RST_HIGH_DRIVE;
    end else if (do_write && hit_hdrv) begin
      high_drive_select <= wdata & gpc_pkg::MASK_HIGH_DRIVE;
    end
  end

  always_ff @(posedge clk) begin
    if (rst || por) begin
      port_write_mask <= gpc_pkg::RST_WRITE_MASK;
    end else if (do_write && hit_wmask) begin
      port_write_mask <= wdata;
    end
  end

endmodule : gpc_port

//--- inc/gpc_pkg.sv
// Package: register map, reset values and pin indices of the GPIO port
package gpc_pkg;

  // ==========================================================
  // Sizes
  localparam int PORT_W = 8;
  localparam int APB_AW = 8;
  localparam int APB_DW = 32;

  // ==========================================================
  // Register byte offsets
  localparam logic [7:0] OFS_PORT_PIN_VALUE  = 8'h00;
  localparam logic [7:0] OFS_PIN_DIRECTION   = 8'h04;
  localparam logic [7:0] OFS_OUTPUT_LATCH    = 8'h08;
  localparam logic [7:0] OFS_OPEN_DRAIN      = 8'h0C;
  localparam logic [7:0] OFS_SLEW_LIMIT      = 8'h10;
  localparam logic [7:0] OFS_INPUT_THRESHOLD = 8'h14;
  localparam logic [7:0] OFS_ANALOG_SELECT   = 8'h18;
  localparam logic [7:0] OFS_HIGH_DRIVE      = 8'h1C;
  localparam logic [7:0] OFS_WRITE_MASK      = 8'h20;

  // ==========================================================
  // Reset values
  localparam logic [7:0] RST_PIN_DIRECTION   = 8'hFF;
  localparam logic [7:0] RST_OUTPUT_LATCH    = 8'h00;
  localparam logic [7:0] RST_OPEN_DRAIN      = 8'h00;
  localparam logic [7:0] RST_SLEW_LIMIT      = 8'hFF;
  localparam logic [7:0] RST_INPUT_THRESHOLD = 8'h00;
  localparam logic [7:0] RST_ANALOG_SELECT   = 8'hCF;
  localparam logic [7:0] RST_HIGH_DRIVE      = 8'h00;
  localparam logic [7:0] RST_WRITE_MASK      = 8'hFF;

  // ==========================================================
  // Implemented bits
  localparam logic [7:0] MASK_ANALOG_SELECT  = 8'hCF;
  localparam logic [7:0] MASK_HIGH_DRIVE     = 8'h30;

  // ==========================================================
  // High-drive pin positions
  localparam int HIGH_DRIVE_PIN_A = 4;
  localparam int HIGH_DRIVE_PIN_B = 5;

  // ==========================================================
  // Bus answer values
  localparam logic [31:0] READ_ZERO = 32'h0000_0000;

endpackage : gpc_pkg

//--- testbench/gpc_pad_model.sv
// Board-side pad model: pins, external drivers, pull-ups
module gpc_pad_model (
  input  wire logic [7:0] drv_val,
  input  wire logic [7:0] drv_en,
  input  wire logic [7:0] ext_val,
  input  wire logic [7:0] ext_en,
  input  wire logic [7:0] ttl_skew,
  output logic      [7:0] lvl_schmitt,
  output logic      [7:0] lvl_ttl
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [7:0] lvl;
  // Released pins float up through board pull-ups
  assign lvl = (drv_en & drv_val) | (~drv_en & ext_en & ext_val)
             | (~drv_en & ~ext_en);
  assign lvl_schmitt = lvl;
  // Marginal levels that the TTL comparator resolves the other way
  assign lvl_ttl = lvl ^ ttl_skew;
endmodule : gpc_pad_model

//--- testbench/gpc_port_monitor.sv
// Checker: port-level properties of the GPIO port
module gpc_port_monitor #(
  parameter int WIDTH = 8
) (
  input wire logic              clk,
  input wire logic              rst,
  input wire logic              por,
  input wire logic              ce,
  input wire logic              psel,
  input wire logic              penable,
  input wire logic              pwrite,
  input wire logic [7:0]        paddr,
  input wire logic [31:0]       pwdata,
  input wire logic [3:0]        pstrb,
  input wire logic              pready,
  input wire logic [31:0]       prdata,
  input wire logic              pslverr,
  input wire logic [WIDTH-1:0]  pin_in_schmitt,
  input wire logic [WIDTH-1:0]  pin_in_ttl,
  input wire logic [WIDTH-1:0]  port_pins_oe,
  input wire logic [WIDTH-1:0]  pin_slew_limit,
  input wire logic [WIDTH-1:0]  pin_high_drive,
  input wire logic [WIDTH-1:0]  pin_analog_enable,
  input wire logic [WIDTH-1:0]  pin_digital_in
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst || por);
  logic wr_ok;
  assign wr_ok = pready && pwrite && pstrb[0] && !pslverr;
  // ==========================================================
  // Properties
  a_ready_first: assert property (
    psel && !penable && ce ##1 psel && penable && ce |-> pready)
    else $error("pready missing in first access cycle");
  a_unmapped_err: assert property (
    pready && paddr > 8'h20 |-> pslverr && prdata == 32'h0)
    else $error("unmapped access not refused");
  a_upper_zero: assert property (
    pready && !pwrite |-> prdata[31:8] == 24'h0)
    else $error("read data upper bits not zero");
  a_analog_zero: assert property (
    (pin_digital_in & pin_analog_enable) == '0)
    else $error("analog pin reads one");
  a_hidrv_pins: assert property (
    (pin_high_drive & ~gpc_pkg::MASK_HIGH_DRIVE) == 8'h00)
    else $error("high drive on wrong pin");
  a_dir_off: assert property (
    wr_ok && paddr == gpc_pkg::OFS_PIN_DIRECTION ##1 ce
    |=> (port_pins_oe & $past(pwdata[7:0], 2)) == 8'h00)
    else $error("input pin still driven");
  a_analog_copy: assert property (
    wr_ok && paddr == gpc_pkg::OFS_ANALOG_SELECT |=> pin_analog_enable
    == ($past(pwdata[7:0]) & gpc_pkg::MASK_ANALOG_SELECT))
    else $error("analog enable not updated");
  a_slew_copy: assert property (
    wr_ok && paddr == gpc_pkg::OFS_SLEW_LIMIT
    |=> pin_slew_limit == $past(pwdata[7:0]))
    else $error("slew limit not updated");
  a_sync_latency: assert property (
    (ce && pin_in_schmitt == pin_in_ttl && $stable(pin_in_schmitt)
     && pin_analog_enable == '0)[*6] |-> pin_digital_in == pin_in_schmitt)
    else $error("pin level not seen in time");
  c_write: cover property (wr_ok);
  c_error: cover property (pready && pslverr);
  c_stall: cover property (psel && penable && !ce);
endmodule : gpc_port_monitor

bind gpc_port gpc_port_monitor #(.WIDTH(WIDTH)) i_monitor (.clk, .rst,
  .por, .ce, .psel, .penable, .pwrite, .paddr, .pwdata, .pstrb, .pready,
  .prdata, .pslverr, .pin_in_schmitt, .pin_in_ttl, .port_pins_oe,
  .pin_slew_limit, .pin_high_drive, .pin_analog_enable, .pin_digital_in);

//--- testbench/tb_top.sv
// Testbench top: APB master, pad model and port scenarios
module tb_top;
  timeunit 1ns;
  timeprecision 1ns;
  logic        clk = 0, rst = 1, por = 1, ce = 1, pready, pslverr, er;
  logic        psel = 0, penable = 0, pwrite = 0;
  logic [7:0]  paddr = 8'h00, fsel = 8'h00, fout = 8'h00;
  logic [31:0] pwdata = 32'h0, prdata, rd;
  logic [3:0]  pstrb = 4'hF;
  logic [7:0]  schm, ttl, pout, poe, slew, hid, ana, din;
  logic [7:0]  ext_val = 8'h00, ext_en = 8'h00, skew = 8'h00;
  int          err_count = 0, comparisons = 0;
  always #25 clk = ~clk;
  gpc_port i_dut (.clk, .rst, .por, .ce, .psel, .penable, .pwrite,
    .paddr, .pwdata, .pstrb, .pready, .prdata, .pslverr,
    .pin_in_schmitt(schm), .pin_in_ttl(ttl), .port_pins_out(pout),
    .port_pins_oe(poe), .pin_slew_limit(slew), .pin_high_drive(hid),
    .pin_analog_enable(ana), .periph_select(fsel), .periph_out(fout),
    .pin_digital_in(din));
  gpc_pad_model i_pads (.drv_val(pout), .drv_en(poe), .ext_val, .ext_en,
    .ttl_skew(skew), .lvl_schmitt(schm), .lvl_ttl(ttl));
  // ==========================================================
  // Bus and compare tasks
  task automatic chk(input logic [7:0] g, input logic [7:0] e);
    comparisons++;
    if (g !== e) begin
      err_count++;
      $display("MISMATCH t=%0t got %h exp %h", $time, g, e);
    end
  endtask : chk
  task automatic apb(input logic w, input logic [7:0] a,
                     input logic [7:0] d);
    @(posedge clk);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= w;
    paddr   <= a;
    pwdata  <= {24'h0, d};
    @(posedge clk);
    penable <= 1'b1;
    // Request stands until pready is seen at a rising edge
    @(posedge clk);
    while (pready !== 1'b1) begin
      @(posedge clk);
    end
    rd = prdata;
    er = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask : apb
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    apb(1'b1, a, d);
  endtask : wr
  task automatic rd8(input logic [7:0] a, input logic [7:0] e);
    apb(1'b0, a, 8'h00);
    chk(rd[7:0], e);
  endtask : rd8
  task automatic tick(input int k);
    repeat (k) @(negedge clk);
  endtask : tick
  task automatic note(input string s);
    $display("test %s finished, %0d mismatches so far", s, err_count);
  endtask : note
  // ==========================================================
  // Scenarios
  task automatic t_reset;
    logic [7:0] e [8];
    e = '{8'hFF, 8'h00, 8'h00, 8'hFF, 8'h00, 8'hCF, 8'h00, 8'hFF};
    for (int i = 0; i < 8; i++) begin
      rd8(8'(4 * i + 4), e[i]);
    end
    chk(poe, 8'h00);
    note("reset");
  endtask : t_reset
  task automatic t_drive;
    wr(8'h18, 8'h00);
    wr(8'h08, 8'hA5);
    wr(8'h04, 8'h00);
    tick(6);
    chk(pout, 8'hA5);
    chk(poe, 8'hFF);
    rd8(8'h00, 8'hA5);
    wr(8'h0C, 8'hFF);
    tick(2);
    chk(pout, 8'h00);
    chk(poe, 8'h5A);
    wr(8'h0C, 8'h0F);
    tick(2);
    chk(pout, 8'hA0);
    chk(poe, 8'hFA);
    wr(8'h1C, 8'hFF);
    wr(8'h10, 8'h00);
    tick(1);
    chk(hid, 8'h30);
    chk(slew, 8'h00);
    rd8(8'h1C, 8'h30);
    note("drive");
  endtask : t_drive
  task automatic t_rmw;
    wr(8'h0C, 8'h00);
    wr(8'h04, 8'hF0);
    ext_en  <= 8'hF0;
    ext_val <= 8'h30;
    wr(8'h20, 8'h0F);
    tick(6);
    wr(8'h00, 8'h5A);
    rd8(8'h08, 8'h3A);
    wr(8'h20, 8'hFF);
    wr(8'h00, 8'hF3);
    rd8(8'h08, 8'hF3);
    note("rmw");
  endtask : t_rmw
  task automatic t_analog;
    ext_en <= 8'h00;
    wr(8'h04, 8'h00);
    wr(8'h18, 8'hFF);
    tick(6);
    chk(pout, 8'hF3);
    chk(poe, 8'hFF);
    chk(ana, 8'hCF);
    rd8(8'h00, 8'h30);
    wr(8'h04, 8'hFF);
    wr(8'h18, 8'h00);
    note("analog");
  endtask : t_analog
  task automatic t_misc;
    wr(8'h08, 8'h00);
    wr(8'h04, 8'h00);
    fsel <= 8'h01;
    fout <= 8'h01;
    tick(2);
    chk(pout, 8'h01);
    @(posedge clk);
    fsel <= 8'h00;
    apb(1'b0, 8'h24, 8'h00);
    chk({7'h0, er}, 8'h01);
    chk(rd[7:0], 8'h00);
    // Strobe without the low byte must leave the latch alone
    pstrb <= 4'hE;
    wr(8'h08, 8'hFF);
    pstrb <= 4'hF;
    rd8(8'h08, 8'h00);
    note("misc");
  endtask : t_misc
  task automatic t_thr;
    wr(8'h04, 8'hFF);
    ext_en  <= 8'hFF;
    ext_val <= 8'h0F;
    skew    <= 8'h3C;
    tick(6);
    rd8(8'h00, 8'h33);
    wr(8'h14, 8'hFF);
    // Clock enable drops during the access phase and stalls it
    fork
      rd8(8'h00, 8'h0F);
      begin
        repeat (2) @(posedge clk);
        ce <= 1'b0;
        repeat (3) @(posedge clk);
        ce <= 1'b1;
      end
    join
    chk(din, 8'h0F);
    note("threshold");
  endtask : t_thr
  task automatic t_por;
    ext_en <= 8'h00;
    skew   <= 8'h00;
    wr(8'h08, 8'h5A);
    @(posedge clk);
    rst <= 1'b1;
    @(posedge clk);
    rst <= 1'b0;
    rd8(8'h08, 8'h5A);
    @(posedge clk);
    por <= 1'b1;
    @(posedge clk);
    por <= 1'b0;
    rd8(8'h08, 8'h00);
    note("por");
  endtask : t_por
  // ==========================================================
  // Sequence, watchdog and verdict
  task automatic end_of_test;
    $display("Counts: %0d mismatches, %0d comparisons", err_count,
             comparisons);
    if (err_count == 0 && comparisons > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask : end_of_test
  initial begin
    repeat (5) @(posedge clk);
    rst <= 1'b0;
    por <= 1'b0;
    t_reset();
    t_drive();
    t_rmw();
    t_analog();
    t_misc();
    t_thr();
    t_por();
    end_of_test();
  end
  initial begin
    #200us;
    err_count++;
    end_of_test();
  end
endmodule : tb_top
